// ---- rtl/nvmac_consts.svh ----
// Offsets, field positions, reset values and timing counts of the byte store controller
`ifndef NVMAC_CONSTS_SVH
`define NVMAC_CONSTS_SVH
`define NVMAC_CTRL_SECTOR 2'h1
`define NVMAC_CTRL_OFS 8'h40
`define NVMAC_ADDR_OFS 8'h2C
`define NVMAC_DATA_OFS 8'h2D
`define NVMAC_B_STORE_PERMIT 3
`define NVMAC_B_STORE_GO 2
`define NVMAC_B_FETCH_PERMIT 1
`define NVMAC_B_FETCH_GO 0
`define NVMAC_CTRL_RST 4'h0
`define NVMAC_RD_CYCLES 2
`define NVMAC_WR_TICKS 16
`define NVMAC_ADDR_W 8
`endif

// ---- rtl/nvmac_pkg.sv ----
// Types shared by the byte store controller
package nvmac_pkg;
    typedef enum logic [2:0] {
        NVMAC_IDLE  = 3'b001,
        NVMAC_FETCH = 3'b010,
        NVMAC_STORE = 3'b100
    } nvmac_state_t;
endpackage

// ---- rtl/nvmac_wtimer.sv ----
// Write cycle timer paced by a free-running tick from an unrelated oscillator
`timescale 1ns/100ps
`include "nvmac_consts.svh"
module nvmac_wtimer #(
    parameter int TICKS = `NVMAC_WR_TICKS
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic tick_pin,
    input wire logic start,
    output logic done
);
    logic sync1;
    logic sync2;
    logic sync3;
    logic tick_lvl;
    logic running;
    logic [15:0] cnt;
    wire tick_rise = sync2 & sync3 & ~tick_lvl;
    wire last_tick = (cnt == 16'(TICKS - 1));

    // Three-stage capture of the foreign tick
    always_ff @(posedge core_clk) begin
        sync1 <= tick_pin;
        sync2 <= sync1;
        sync3 <= sync2;
    end

    // Filtered level follows only when stages two and three agree
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tick_lvl <= 1'b0;
        end else if (sync2 == sync3) begin
            tick_lvl <= sync3;
        end
    end

    // Tick counter; end time is not a fixed count of core clocks
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            running <= 1'b0;
            cnt <= 16'h0000;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                running <= 1'b1;
                cnt <= 16'h0000;
            end else if (running && tick_rise) begin
                if (last_tick) begin
                    running <= 1'b0;
                    done <= 1'b1;
                end else begin
                    cnt <= cnt + 16'h0001;
                end
            end
        end
    end
endmodule

// ---- rtl/nvmac_ctrl.sv ----
// Byte-wide nonvolatile data store with address, data and control registers
//
// Behaviour
// - Store holds 128 bytes (7-bit address) or 256 bytes (8-bit address).
// - Array is not memory mapped; each access moves one byte via three registers.
// - Control register sits at offset 40h of sector 1, indirect access only.
// - Narrow variant: address bits 6..0 used, bit 7 reads zero.
// - Wide variant: all eight address bits read and write, no reset value.
// - Data register keeps its value until the next read cycle or a direct write to it.
// - Control bits 7..4 read zero; low four bits reset to zero.
// - Bit 3 permits writes; without it no write cycle can occur.
// - Writing one to bit 2 starts a write; hardware clears it when done.
// - Write start without write permission already set does nothing.
// - Bit 1 permits reads; without it no read cycle can occur.
// - Writing one to bit 0 starts a read; hardware clears it when done.
// - Read start without read permission already set is ignored.
// - Write cycle is timed by a timer asynchronous to the system clock.
// - Each finished write sets a done flag that only software clears.
`timescale 1ns/100ps
`include "nvmac_consts.svh"
module nvmac_ctrl #(
    parameter int ADDR_W = `NVMAC_ADDR_W,
    parameter int WR_TICKS = `NVMAC_WR_TICKS
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic sfr_indirect,
    input wire logic [1:0] sfr_sector,
    input wire logic [7:0] sfr_offset,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic wtimer_tick,
    input wire logic done_clr,
    output logic nvm_done_flag
);
    localparam int DEPTH = 1 << ADDR_W;
    localparam logic [7:0] ADDR_MASK = 8'((1 << ADDR_W) - 1);
    localparam logic [1:0] RD_LAST = 2'(`NVMAC_RD_CYCLES - 1);

    logic [7:0] mem [DEPTH];
    logic [7:0] nvm_addr_reg;
    logic [7:0] nvm_byte_reg;
    logic store_permit;
    logic fetch_permit;
    logic store_go;
    logic fetch_go;
    logic [7:0] lat_addr;
    logic [7:0] lat_data;
    logic [1:0] rd_cnt;
    logic wr_done;
    nvmac_pkg::nvmac_state_t state;
    nvmac_pkg::nvmac_state_t next_state;

    // Direct decode of a sector-independent register
    function automatic logic direct_hit(input logic [7:0] ofs, input logic [7:0] want);
        direct_hit = (ofs == want);
    endfunction

    // Register decode
    wire ctrl_hit = sfr_indirect && (sfr_sector == `NVMAC_CTRL_SECTOR)
                    && (sfr_offset == `NVMAC_CTRL_OFS);
    wire addr_hit = !sfr_indirect && direct_hit(sfr_offset, `NVMAC_ADDR_OFS);
    wire data_hit = !sfr_indirect && direct_hit(sfr_offset, `NVMAC_DATA_OFS);
    wire ctrl_wr = sfr_wr && ctrl_hit;
    wire idle = (state == nvmac_pkg::NVMAC_IDLE);
    wire [7:0] ctrl_view = {4'h0, store_permit, store_go, fetch_permit, fetch_go};

    // Starts qualified by permission already held; write wins if both raised
    wire go_store = ctrl_wr && sfr_wdata[`NVMAC_B_STORE_GO] && store_permit && idle;
    wire go_fetch = ctrl_wr && sfr_wdata[`NVMAC_B_FETCH_GO] && fetch_permit && idle
                    && !go_store;
    wire rd_done = (state == nvmac_pkg::NVMAC_FETCH) && (rd_cnt == RD_LAST);
    wire [ADDR_W-1:0] mem_idx = lat_addr[ADDR_W-1:0];

    // Next state
    always_comb begin
        next_state = state;
        unique case (state)
            nvmac_pkg::NVMAC_IDLE: begin
                if (go_store) begin
                    next_state = nvmac_pkg::NVMAC_STORE;
                end else if (go_fetch) begin
                    next_state = nvmac_pkg::NVMAC_FETCH;
                end
            end
            nvmac_pkg::NVMAC_FETCH: begin
                if (rd_done) begin
                    next_state = nvmac_pkg::NVMAC_IDLE;
                end
            end
            nvmac_pkg::NVMAC_STORE: begin
                if (wr_done) begin
                    next_state = nvmac_pkg::NVMAC_IDLE;
                end
            end
            default: next_state = nvmac_pkg::NVMAC_IDLE;
        endcase
    end

    // Write timer on the foreign tick
    nvmac_wtimer #(
        .TICKS(WR_TICKS)
    ) u_wtimer (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .tick_pin(wtimer_tick),
        .start(go_store),
        .done(wr_done)
    );

    // Control bits, state and read pacing
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            {store_permit, store_go, fetch_permit, fetch_go} <= `NVMAC_CTRL_RST;
            state <= nvmac_pkg::NVMAC_IDLE;
            rd_cnt <= 2'h0;
        end else begin
            state <= next_state;
            rd_cnt <= (state == nvmac_pkg::NVMAC_FETCH) ? rd_cnt + 2'h1 : 2'h0;
            if (ctrl_wr) begin
                store_permit <= sfr_wdata[`NVMAC_B_STORE_PERMIT];
                fetch_permit <= sfr_wdata[`NVMAC_B_FETCH_PERMIT];
            end
            if (go_store) begin
                store_go <= 1'b1;
            end else if (wr_done) begin
                store_go <= 1'b0;
            end
            if (go_fetch) begin
                fetch_go <= 1'b1;
            end else if (rd_done) begin
                fetch_go <= 1'b0;
            end
        end
    end

    // Address capture at cycle start so later loads cannot disturb a cycle
    always_ff @(posedge core_clk) begin
        if (sfr_wr && addr_hit) begin
            nvm_addr_reg <= sfr_wdata & ADDR_MASK;
        end
        if (go_store || go_fetch) begin
            lat_addr <= nvm_addr_reg;
            lat_data <= nvm_byte_reg;
        end
    end

    // Array write and data register load, one byte per cycle
    always_ff @(posedge core_clk) begin
        if (wr_done) begin
            mem[mem_idx] <= lat_data;
        end
        if (rd_done) begin
            nvm_byte_reg <= mem[mem_idx];
        end else if (sfr_wr && data_hit) begin
            nvm_byte_reg <= sfr_wdata;
        end
    end

    // Done flag: a set in the clearing cycle wins
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            nvm_done_flag <= 1'b0;
        end else if (wr_done) begin
            nvm_done_flag <= 1'b1;
        end else if (done_clr) begin
            nvm_done_flag <= 1'b0;
        end
    end

    // Registered read port
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            sfr_rdata <= ctrl_hit ? ctrl_view
                       : addr_hit ? (nvm_addr_reg & ADDR_MASK)
                       : data_hit ? nvm_byte_reg : 8'h00;
        end
    end

    // Checks
    wire rd_ctrl = sfr_rd && ctrl_hit;
    wire rd_addr = sfr_rd && addr_hit;

    a_wr_no_permit: assert property (@(posedge core_clk) disable iff (!rst_n)
        ctrl_wr && sfr_wdata[2] && !store_permit && idle |=> !store_go)
        else $error("write started without permission");
    a_rd_no_permit: assert property (@(posedge core_clk) disable iff (!rst_n)
        ctrl_wr && sfr_wdata[0] && !fetch_permit && idle |=> !fetch_go)
        else $error("read started without permission");
    a_rd_cycle_len: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(fetch_go) |=> fetch_go ##1 !fetch_go)
        else $error("read cycle length wrong");
    a_rd_loads_byte: assert property (@(posedge core_clk) disable iff (!rst_n)
        $fell(fetch_go) |-> nvm_byte_reg == mem[mem_idx])
        else $error("read data not loaded");
    a_wr_start_held: assert property (@(posedge core_clk) disable iff (!rst_n)
        store_go && !wr_done |=> store_go)
        else $error("write start dropped early");
    a_wr_stores_byte: assert property (@(posedge core_clk) disable iff (!rst_n)
        $fell(store_go) |-> mem[mem_idx] == lat_data && nvm_done_flag)
        else $error("write byte not stored");
    a_done_flag_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
        nvm_done_flag && !done_clr |=> nvm_done_flag)
        else $error("done flag lost");
    a_ctrl_high_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
        rd_ctrl |=> sfr_rdata[7:4] == 4'h0)
        else $error("control high bits not zero");
    a_addr_narrow: assert property (@(posedge core_clk) disable iff (!rst_n)
        rd_addr && ADDR_W < 8 |=> !sfr_rdata[7])
        else $error("unused address bit not zero");
    a_one_cycle_kind: assert property (@(posedge core_clk) disable iff (!rst_n)
        !(store_go && fetch_go))
        else $error("read and write cycles overlap");
    a_data_stable: assert property (@(posedge core_clk) disable iff (!rst_n)
        !rd_done && !(sfr_wr && data_hit) |=> $stable(nvm_byte_reg))
        else $error("data register changed unprompted");

    c_read_done: cover property (@(posedge core_clk) disable iff (!rst_n) $fell(fetch_go));
    c_write_done: cover property (@(posedge core_clk) disable iff (!rst_n) $fell(store_go));
    c_write_refused: cover property (@(posedge core_clk) disable iff (!rst_n)
        ctrl_wr && sfr_wdata[2] && !store_permit);
endmodule

// ---- dv/nvmac_ctrl_tb.sv ----
// Self-checking bench for the byte store controller
`timescale 1ns/100ps
`include "nvmac_consts.svh"
module nvmac_ctrl_tb;
    localparam int TICKS = 3;
    logic core_clk, rst_n, sfr_wr, sfr_rd, sfr_indirect, wtimer_tick, done_clr;
    logic [1:0] sfr_sector;
    logic [7:0] sfr_offset, sfr_wdata, sfr_rdata, got;
    logic nvm_done_flag;
    logic [7:0] narrow_rdata;
    logic narrow_done;
    int n_mismatch = 0;
    int checks_done = 0;
    int cycles = 0;

    nvmac_ctrl #(.ADDR_W(8), .WR_TICKS(TICKS)) nvmac_ctrl_inst (
        .core_clk(core_clk), .rst_n(rst_n), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_indirect(sfr_indirect), .sfr_sector(sfr_sector), .sfr_offset(sfr_offset),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .wtimer_tick(wtimer_tick),
        .done_clr(done_clr), .nvm_done_flag(nvm_done_flag));

    // Narrow 128-byte variant on the same bus, same tick
    nvmac_ctrl #(.ADDR_W(7), .WR_TICKS(TICKS)) nvmac_ctrl_narrow_inst (
        .core_clk(core_clk), .rst_n(rst_n), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_indirect(sfr_indirect), .sfr_sector(sfr_sector), .sfr_offset(sfr_offset),
        .sfr_wdata(sfr_wdata), .sfr_rdata(narrow_rdata), .wtimer_tick(wtimer_tick),
        .done_clr(done_clr), .nvm_done_flag(narrow_done));

    // Core clock, 4 ns period
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // Unrelated free-running timer oscillator, 74 ns period
    initial begin
        wtimer_tick = 1'b0;
        #5.3;
        forever #37 wtimer_tick = ~wtimer_tick;
    end

    // Hang guard
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_mismatch++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One register access, entered and left at a falling edge
    task automatic acc(input logic wr, input logic ind, input logic [7:0] ofs,
                       input logic [7:0] wd, output logic [7:0] rd);
        sfr_wr = wr;
        sfr_rd = ~wr;
        sfr_indirect = ind;
        sfr_sector = ind ? `NVMAC_CTRL_SECTOR : 2'h0;
        sfr_offset = ofs;
        sfr_wdata = wd;
        @(negedge core_clk);
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        @(negedge core_clk);
        rd = sfr_rdata;
    endtask

    task automatic wr_reg(input logic ind, input logic [7:0] ofs, input logic [7:0] wd);
        logic [7:0] dummy;
        acc(1'b1, ind, ofs, wd, dummy);
    endtask

    task automatic rd_reg(input logic ind, input logic [7:0] ofs, output logic [7:0] rd);
        acc(1'b0, ind, ofs, 8'h00, rd);
    endtask

    // Poll the control register until the given start bit falls
    task automatic wait_clear(input int bitpos, input int limit, output logic [7:0] c);
        for (int i = 0; i < limit; i++) begin
            rd_reg(1'b1, `NVMAC_CTRL_OFS, c);
            if (c[bitpos] === 1'b0)
                break;
        end
    endtask

    task automatic test_reset();
        rd_reg(1'b1, `NVMAC_CTRL_OFS, got);
        chk("ctrl after reset", 8'h00, got);
        chk("done after reset", 8'h00, {7'h00, nvm_done_flag});
        wr_reg(1'b1, `NVMAC_CTRL_OFS, 8'hF0);
        rd_reg(1'b1, `NVMAC_CTRL_OFS, got);
        chk("ctrl high nibble", 8'h00, got);
        wr_reg(1'b0, `NVMAC_CTRL_OFS, 8'h0A);
        rd_reg(1'b1, `NVMAC_CTRL_OFS, got);
        chk("ctrl not direct", 8'h00, got);
        $display("test reset done");
    endtask

    task automatic test_refused();
        wr_reg(1'b1, `NVMAC_CTRL_OFS, 8'h04);
        rd_reg(1'b1, `NVMAC_CTRL_OFS, got);
        chk("store go without permit", 8'h00, got);
        wr_reg(1'b1, `NVMAC_CTRL_OFS, 8'h01);
        rd_reg(1'b1, `NVMAC_CTRL_OFS, got);
        chk("fetch go without permit", 8'h00, got);
        $display("test refused done");
    endtask

    task automatic test_store(input logic [7:0] a, input logic [7:0] d);
        wr_reg(1'b0, `NVMAC_ADDR_OFS, a);
        wr_reg(1'b0, `NVMAC_DATA_OFS, d);
        wr_reg(1'b1, `NVMAC_CTRL_OFS, 8'h08);
        wr_reg(1'b1, `NVMAC_CTRL_OFS, 8'h0C);
        rd_reg(1'b1, `NVMAC_CTRL_OFS, got);
        chk("store go held", 8'h0C, got);
        wait_clear(`NVMAC_B_STORE_GO, 400, got);
        chk("store go cleared", 8'h08, got);
        chk("done set", 8'h01, {7'h00, nvm_done_flag});
        chk("narrow done set", 8'h01, {7'h00, narrow_done});
        done_clr = 1'b1;
        @(negedge core_clk);
        done_clr = 1'b0;
        @(negedge core_clk);
        chk("done cleared", 8'h00, {7'h00, nvm_done_flag});
        wr_reg(1'b1, `NVMAC_CTRL_OFS, 8'h00);
        $display("test store done");
    endtask

    task automatic test_fetch(input logic [7:0] a, input logic [7:0] d);
        wr_reg(1'b1, `NVMAC_CTRL_OFS, 8'hF2);
        wr_reg(1'b0, `NVMAC_ADDR_OFS, a);
        wr_reg(1'b0, `NVMAC_DATA_OFS, ~d);
        wr_reg(1'b1, `NVMAC_CTRL_OFS, 8'h03);
        wait_clear(`NVMAC_B_FETCH_GO, 10, got);
        chk("fetch go cleared", 8'h02, got);
        rd_reg(1'b0, `NVMAC_DATA_OFS, got);
        chk("fetched byte", d, got);
        chk("narrow fetched byte", d, narrow_rdata);
        rd_reg(1'b0, `NVMAC_ADDR_OFS, got);
        chk("address kept", a, got);
        chk("narrow address", a & 8'h7F, narrow_rdata);
        repeat (5) @(negedge core_clk);
        rd_reg(1'b0, `NVMAC_DATA_OFS, got);
        chk("data held", d, got);
        wr_reg(1'b1, `NVMAC_CTRL_OFS, 8'h00);
        $display("test fetch done");
    endtask

    // Main sequence
    initial begin
        rst_n = 1'b0;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_indirect = 1'b0;
        sfr_sector = 2'h0;
        sfr_offset = 8'h00;
        sfr_wdata = 8'h00;
        done_clr = 1'b0;
        repeat (8) @(negedge core_clk);
        rst_n = 1'b1;
        @(negedge core_clk);
        test_reset();
        test_refused();
        test_store(8'hFF, 8'h3C);
        test_store(8'h00, 8'hC5);
        test_fetch(8'hFF, 8'h3C);
        test_fetch(8'h00, 8'hC5);
        complete_run();
    end
endmodule
